// file: include/e1_ovh_pkg.sv
// constants, field layouts and carrier types of the e1 transmit overhead
// source selector; assumes an 8-bit register port with 12-bit addresses.
`default_nettype none
package e1_ovh_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] SYNC_MUX_OFS = 12'h100;
  localparam logic [11:0] LINK_CTRL_OFS = 12'h109;
  localparam logic [11:0] SIG_LINK_SEL_OFS = 12'h10a;
  localparam logic [11:0] SA_SEL_OFS = 12'h130;
  localparam logic [11:0] SA_VAL_OFS = 12'h131;
  localparam logic [11:0] STATUS_OFS = 12'h132;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int ALIGN_SRC_BIT = 0;
  localparam int CRC_SRC_BIT = 1;
  localparam int EBIT_SRC_LSB = 6;
  localparam int LINK_CODE_LSB = 0;
  localparam int CRC_MF_EN_BIT = 2;
  localparam int ALARM_BIT = 3;
  localparam int NAT_LSB = 4;
  localparam logic [7:0] SYNC_MUX_RST = 8'h00;
  localparam logic [7:0] LINK_CTRL_RST = 8'h00;
  localparam logic [7:0] SIG_LINK_SEL_RST = 8'h00;
  localparam logic [7:0] SA_SEL_RST = 8'h00;
  localparam logic [7:0] SA_VAL_RST = 8'h00;

  // ****************************************************************
  // codes, patterns and counts
  // ****************************************************************
  localparam logic [1:0] LINK_HDLC = 2'h1;
  localparam logic [1:0] LINK_OVH = 2'h2;
  localparam logic [1:0] EBIT_NONE = 2'h0;
  localparam logic [1:0] EBIT_FAR = 2'h1;
  localparam logic [1:0] EBIT_ZERO = 2'h2;
  // fas word indexed by position 1..7 within timeslot 0
  localparam logic [7:0] FAS_PAT = 8'hd8;
  // multiframe word indexed by odd frame number / 2, frames 1..11
  localparam logic [5:0] MF_PAT = 6'h34;
  localparam int FRAME_BITS = 256;
  localparam int TS0_BITS = 8;
  localparam logic [3:0] EBIT_FRM_A = 4'hd;
  localparam logic [3:0] EBIT_FRM_B = 4'hf;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic data;
  } ser_t;

  typedef struct packed {
    logic fstart;
    logic data;
  } line_t;
endpackage
`default_nettype wire

// file: rtl/e1_ovh_buf.sv
// small shift fifo with valid/ready on both sides;
// assumes one clock and a synchronous active-low reset.
`default_nettype none
module e1_ovh_buf #(
  parameter int W = 2,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] in_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_r [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] wr_idx;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign wr_idx = pop ? cnt_r - CW'(1) : cnt_r;
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  assign out_o = mem_r[0];

  // head always sits in entry 0 so the output is a plain flop
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i + 1 < DEPTH) begin
        mem_r[i] <= mem_r[i+1];
      end
      if (push && CW'(i) == wr_idx) begin
        mem_r[i] <= in_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready_o <= cnt_nxt != CW'(DEPTH);
      out_valid_o <= cnt_nxt != '0;
    end
  end
endmodule
`default_nettype wire

// file: rtl/e1_ovh_sel.sv
// transmit e1 timeslot-0 overhead source selector with its registers;
// assumes the serial input carries one bit per accepted beat, frame
// aligned from reset, first beat being bit 0 of timeslot 0 of frame 0.
`default_nettype none
module e1_ovh_sel #(
  parameter int FRAME_BITS = e1_ovh_pkg::FRAME_BITS,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire e1_ovh_pkg::reg_req_t reg_i,
  output logic [7:0] rdata_o,
  input wire e1_ovh_pkg::ser_t tx_serial_in_i,
  input wire logic tx_serial_valid_i,
  output logic tx_serial_ready_o,
  input wire logic hdlc_bit_i,
  input wire logic tx_overhead_port_i,
  input wire logic [1:0] far_err_i,
  output logic hdlc_take_o,
  output logic ovh_take_o,
  output e1_ovh_pkg::line_t line_o,
  output logic line_valid_o,
  input wire logic line_ready_i
);
  localparam int BW = $clog2(FRAME_BITS);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] sync_source_mux_r;
  logic [7:0] link_ctrl_r;
  logic [7:0] tx_signaling_link_select_r;
  logic [7:0] sa_sel_r;
  logic [7:0] sa_val_r;
  logic [7:0] rdata_nxt;

  // active copies, loaded at frame boundary
  logic [7:0] act_sync_r;
  logic [7:0] act_link_r;
  logic [7:0] act_sig_r;
  logic [7:0] act_sel_r;
  logic [7:0] act_val_r;

  logic [BW-1:0] bit_cnt_r;
  logic [3:0] frm_cnt_r;
  logic [3:0] crc_r;
  logic [3:0] crc_hold_r;
  logic [3:0] crc_nxt;

  logic fire;
  logic last_bit;
  logic in_ts0;
  logic [2:0] pos;
  logic fas_frm;
  logic crc_on;
  logic crc_ext;
  logic align_ext;
  logic ser_bit;
  logic out_bit;
  logic ebit_int;
  logic crc_in;
  logic buf_ready;
  logic [3:0] nat_bit;
  logic [3:0] use_hdlc;
  logic [3:0] use_ovh;
  logic [1:0] link_code;
  logic [1:0] ebit_src;
  e1_ovh_pkg::line_t line_nxt;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync_source_mux_r <= e1_ovh_pkg::SYNC_MUX_RST;
      link_ctrl_r <= e1_ovh_pkg::LINK_CTRL_RST;
      tx_signaling_link_select_r <= e1_ovh_pkg::SIG_LINK_SEL_RST;
      sa_sel_r <= e1_ovh_pkg::SA_SEL_RST;
      sa_val_r <= e1_ovh_pkg::SA_VAL_RST;
    end else if (reg_i.wr) begin
      case (reg_i.addr)
        e1_ovh_pkg::SYNC_MUX_OFS: sync_source_mux_r <= reg_i.wdata;
        e1_ovh_pkg::LINK_CTRL_OFS: link_ctrl_r <= reg_i.wdata;
        e1_ovh_pkg::SIG_LINK_SEL_OFS: begin
          tx_signaling_link_select_r <= reg_i.wdata;
        end
        e1_ovh_pkg::SA_SEL_OFS: sa_sel_r <= reg_i.wdata;
        e1_ovh_pkg::SA_VAL_OFS: sa_val_r <= reg_i.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_i.addr)
      e1_ovh_pkg::SYNC_MUX_OFS: rdata_nxt = sync_source_mux_r;
      e1_ovh_pkg::LINK_CTRL_OFS: rdata_nxt = link_ctrl_r;
      e1_ovh_pkg::SIG_LINK_SEL_OFS: rdata_nxt = tx_signaling_link_select_r;
      e1_ovh_pkg::SA_SEL_OFS: rdata_nxt = sa_sel_r;
      e1_ovh_pkg::SA_VAL_OFS: rdata_nxt = sa_val_r;
      e1_ovh_pkg::STATUS_OFS: rdata_nxt = {frm_cnt_r, crc_hold_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= reg_i.rd ? rdata_nxt : 8'h00;
    end
  end

  // ****************************************************************
  // frame position
  // ****************************************************************
  assign fire = tx_serial_valid_i & buf_ready;
  assign tx_serial_ready_o = buf_ready;
  assign last_bit = bit_cnt_r == BW'(FRAME_BITS - 1);
  assign in_ts0 = bit_cnt_r < BW'(e1_ovh_pkg::TS0_BITS);
  assign pos = bit_cnt_r[2:0];
  assign fas_frm = ~frm_cnt_r[0];
  assign ser_bit = tx_serial_in_i.data;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bit_cnt_r <= '0;
      frm_cnt_r <= 4'h0;
    end else if (fire) begin
      bit_cnt_r <= last_bit ? '0 : bit_cnt_r + BW'(1);
      if (last_bit) begin
        frm_cnt_r <= frm_cnt_r + 4'h1;
      end
    end
  end

  // a mid-octet change would mix two sources in one ts0 octet
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      act_sync_r <= e1_ovh_pkg::SYNC_MUX_RST;
      act_link_r <= e1_ovh_pkg::LINK_CTRL_RST;
      act_sig_r <= e1_ovh_pkg::SIG_LINK_SEL_RST;
      act_sel_r <= e1_ovh_pkg::SA_SEL_RST;
      act_val_r <= e1_ovh_pkg::SA_VAL_RST;
    end else if (fire && last_bit) begin
      act_sync_r <= sync_source_mux_r;
      act_link_r <= link_ctrl_r;
      act_sig_r <= tx_signaling_link_select_r;
      act_sel_r <= sa_sel_r;
      act_val_r <= sa_val_r;
    end
  end

  // ****************************************************************
  // source decoding
  // ****************************************************************
  assign crc_on = act_link_r[e1_ovh_pkg::CRC_MF_EN_BIT];
  assign crc_ext = crc_on & act_sync_r[e1_ovh_pkg::CRC_SRC_BIT];
  assign align_ext = act_sync_r[e1_ovh_pkg::ALIGN_SRC_BIT];
  assign link_code = act_link_r[e1_ovh_pkg::LINK_CODE_LSB +: 2];
  assign ebit_src = act_sync_r[e1_ovh_pkg::EBIT_SRC_LSB +: 2];

  always_comb begin
    case (ebit_src)
      e1_ovh_pkg::EBIT_NONE: ebit_int = 1'b1;
      e1_ovh_pkg::EBIT_FAR: begin
        ebit_int = frm_cnt_r == e1_ovh_pkg::EBIT_FRM_A ?
                   far_err_i[0] : far_err_i[1];
      end
      e1_ovh_pkg::EBIT_ZERO: ebit_int = 1'b0;
      default: ebit_int = 1'b1;
    endcase
  end

  // one slice per national bit sa5..sa8, sitting at ts0 bits 4..7
  for (genvar j = 0; j < 4; j++) begin : g_nat
    logic en;
    logic host;
    assign en = act_sig_r[e1_ovh_pkg::NAT_LSB + j];
    assign host = act_sel_r[e1_ovh_pkg::NAT_LSB + j];
    assign use_hdlc[j] = en & ~host & link_code == e1_ovh_pkg::LINK_HDLC;
    assign use_ovh[j] = en & ~host & link_code == e1_ovh_pkg::LINK_OVH;
    always_comb begin
      if (host) begin
        nat_bit[j] = act_val_r[e1_ovh_pkg::NAT_LSB + j];
      end else if (!en) begin
        nat_bit[j] = 1'b1;
      end else if (use_hdlc[j]) begin
        nat_bit[j] = hdlc_bit_i;
      end else if (use_ovh[j]) begin
        nat_bit[j] = tx_overhead_port_i;
      end else begin
        nat_bit[j] = ser_bit;
      end
    end
  end

  // ****************************************************************
  // timeslot-0 multiplexer
  // ****************************************************************
  always_comb begin
    out_bit = ser_bit;
    if (in_ts0) begin
      if (pos == 3'h0) begin
        if (crc_on && fas_frm) begin
          out_bit = crc_ext ? ser_bit : crc_hold_r[3 - frm_cnt_r[2:1]];
        end else if (align_ext) begin
          out_bit = ser_bit;
        end else if (!crc_on) begin
          out_bit = 1'b1;
        end else if (frm_cnt_r == e1_ovh_pkg::EBIT_FRM_A ||
                     frm_cnt_r == e1_ovh_pkg::EBIT_FRM_B) begin
          out_bit = ebit_int;
        end else begin
          out_bit = e1_ovh_pkg::MF_PAT[frm_cnt_r[3:1]];
        end
      end else if (fas_frm) begin
        out_bit = align_ext ? ser_bit : e1_ovh_pkg::FAS_PAT[pos];
      end else if (pos == 3'h1) begin
        out_bit = align_ext ? ser_bit : 1'b1;
      end else if (pos == 3'h2) begin
        out_bit = align_ext ? ser_bit :
                  act_link_r[e1_ovh_pkg::ALARM_BIT];
      end else if (pos[2]) begin
        out_bit = nat_bit[pos[1:0]];
      end
    end
  end

  // ****************************************************************
  // crc-4 over each sub-multiframe, crc positions counted as zero
  // ****************************************************************
  assign crc_in = (in_ts0 && pos == 3'h0 && fas_frm) ? 1'b0 : out_bit;

  always_comb begin
    crc_nxt[0] = crc_in ^ crc_r[3];
    crc_nxt[1] = crc_r[0] ^ crc_in ^ crc_r[3];
    crc_nxt[2] = crc_r[1];
    crc_nxt[3] = crc_r[2];
  end

  // the remainder of one sub-multiframe is sent in the next one
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      crc_r <= 4'h0;
      crc_hold_r <= 4'h0;
    end else if (fire) begin
      if (last_bit && frm_cnt_r[2:0] == 3'h7) begin
        crc_hold_r <= crc_nxt;
        crc_r <= 4'h0;
      end else begin
        crc_r <= crc_nxt;
      end
    end
  end

  // ****************************************************************
  // data link consumption strobes and output buffer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hdlc_take_o <= 1'b0;
      ovh_take_o <= 1'b0;
    end else begin
      hdlc_take_o <= fire & in_ts0 & ~fas_frm & pos[2] &
                     use_hdlc[pos[1:0]] & ~act_sel_r[4 + pos[1:0]];
      ovh_take_o <= fire & in_ts0 & ~fas_frm & pos[2] &
                    use_ovh[pos[1:0]];
    end
  end

  assign line_nxt.fstart = bit_cnt_r == '0;
  assign line_nxt.data = out_bit;

  // a stall downstream backs up into the serial source, no bit is lost
  e1_ovh_buf #(
    .W($bits(e1_ovh_pkg::line_t)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_i(line_nxt),
    .in_valid_i(tx_serial_valid_i),
    .in_ready_o(buf_ready),
    .out_o(line_o),
    .out_valid_o(line_valid_o),
    .out_ready_i(line_ready_i)
  );
endmodule
`default_nettype wire

// file: testbench/e1_ovh_sel_properties.sv
// checker for the overhead selector: read port, buffer and take pulses
// sees only the selector's ports; bound to it at the foot of this file
`default_nettype none
module e1_ovh_sel_properties #(
  parameter int FRAME_BITS = 256
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire e1_ovh_pkg::reg_req_t reg_i,
  input wire logic [7:0] rdata_o,
  input wire logic tx_serial_valid_i,
  input wire logic tx_serial_ready_o,
  input wire logic hdlc_take_o,
  input wire logic ovh_take_o,
  input wire e1_ovh_pkg::line_t line_o,
  input wire logic line_valid_o,
  input wire logic line_ready_i
);
  // ****
  // beat positions on both sides of the buffer
  // ****
  logic acc;
  logic pop;
  logic nat_slot;
  logic odd_r;
  int ibit_r;
  int obit_r;
  assign acc = tx_serial_valid_i && tx_serial_ready_o;
  assign pop = line_valid_o && line_ready_i;
  assign nat_slot = acc && odd_r && ibit_r >= 4 && ibit_r <= 7;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ibit_r <= 0;
      odd_r <= 1'b0;
    end else if (acc) begin
      ibit_r <= (ibit_r == FRAME_BITS - 1) ? 0 : ibit_r + 1;
      odd_r <= odd_r ^ (ibit_r == FRAME_BITS - 1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      obit_r <= 0;
    end else if (pop) begin
      obit_r <= (obit_r == FRAME_BITS - 1) ? 0 : obit_r + 1;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_rdata_idle: assert property (!$past(reg_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside its answer cycle");
  a_fstart_mark: assert property (pop |-> line_o.fstart == (obit_r == 0))
    else $error("frame start flag misplaced");
  a_hdlc_slot: assert property (hdlc_take_o |-> $past(nat_slot))
    else $error("link bit drawn outside a national slot");
  a_ovh_slot: assert property (ovh_take_o |-> $past(nat_slot))
    else $error("overhead bit drawn outside a national slot");
  a_take_excl: assert property (!(hdlc_take_o && ovh_take_o))
    else $error("two link sources used at once");
  a_line_hold: assert property (line_valid_o && !line_ready_i |=>
    line_valid_o && $stable(line_o))
    else $error("stalled output word changed");
  a_full_only: assert property ($past(nrst_i) && !tx_serial_ready_o
    |-> line_valid_o)
    else $error("input refused with buffer not full");
  a_first_answer: assert property (acc && !line_valid_o |=> line_valid_o)
    else $error("accepted bit not presented next cycle");
endmodule
bind e1_ovh_sel e1_ovh_sel_properties #(.FRAME_BITS(FRAME_BITS)) u_props (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .reg_i(reg_i),
  .rdata_o(rdata_o),
  .tx_serial_valid_i(tx_serial_valid_i),
  .tx_serial_ready_o(tx_serial_ready_o),
  .hdlc_take_o(hdlc_take_o),
  .ovh_take_o(ovh_take_o),
  .line_o(line_o),
  .line_valid_o(line_valid_o),
  .line_ready_i(line_ready_i)
);
`default_nettype wire

// file: testbench/backplane_src.sv
// backplane serial source with link and overhead bit feeds
// assumes the selector takes a bit on valid and ready at a rising edge
`default_nettype none
module backplane_src #(
  parameter int SEED = 29975
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic ready_i,
  output e1_ovh_pkg::ser_t ser_o,
  output logic valid_o,
  output logic hdlc_o,
  output logic ovh_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = SEED;
  initial begin
    valid_o = 1'b0;
    ser_o = '0;
    hdlc_o = 1'b0;
    ovh_o = 1'b0;
  end
  // offer held until taken; random gaps stand for a slow source
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      valid_o <= 1'b0;
    end else if (!valid_o || ready_i) begin
      if (en_i && 2'($random(seed)) != 2'h0) begin
        valid_o <= 1'b1;
        ser_o.data <= 1'($random(seed));
        hdlc_o <= 1'($random(seed));
        ovh_o <= 1'($random(seed));
      end else begin
        // released lines must not keep looking valid
        valid_o <= 1'b0;
        ser_o.data <= !ser_o.data;
        hdlc_o <= !hdlc_o;
        ovh_o <= !ovh_o;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the e1 timeslot-0 overhead selector
// assumes the partner source and the bound checker are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  e1_ovh_pkg::reg_req_t req = '0;
  logic [7:0] rdata;
  e1_ovh_pkg::ser_t ser;
  e1_ovh_pkg::line_t line;
  logic s_valid, s_ready, hbit, obit, h_take, o_take, l_valid;
  logic l_ready = 1'b0;
  logic en = 1'b0;
  logic stall = 1'b0;
  logic ph = 1'b0;
  logic po = 1'b0;
  logic [1:0] far_err = 2'h1;
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 29975;
  int fr = 0;
  int bt = 0;
  int nb = 0;
  int tgt;
  logic [3:0] e;
  logic [7:0] shd [6] = '{e1_ovh_pkg::SYNC_MUX_RST, e1_ovh_pkg::LINK_CTRL_RST,
    e1_ovh_pkg::SIG_LINK_SEL_RST, e1_ovh_pkg::SA_SEL_RST,
    e1_ovh_pkg::SA_VAL_RST, 8'h00};
  logic [7:0] act [6] = '{e1_ovh_pkg::SYNC_MUX_RST,
    e1_ovh_pkg::LINK_CTRL_RST, e1_ovh_pkg::SIG_LINK_SEL_RST,
    e1_ovh_pkg::SA_SEL_RST, e1_ovh_pkg::SA_VAL_RST, 8'h00};
  // crc-4 model of the line: running remainder, held remainder
  logic [3:0] cr = 4'h0;
  logic [3:0] ch = 4'h0;
  logic [3:0] cn;
  logic cb;
  logic [1:0] lq;
  logic [1:0] eq [$];
  logic [7:0] rq [$];
  logic rd_d = 1'b0;
  // last entry is an unmapped address
  localparam logic [11:0] OFS [6] = '{12'h100, 12'h109, 12'h10a, 12'h130,
    12'h131, 12'h1ff};
  localparam logic [7:0] CFG [6][5] = '{'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h01, 8'hf0, 8'h00, 8'h00},
    '{8'h42, 8'h06, 8'h50, 8'h80, 8'h80}, '{8'h80, 8'h0d, 8'ha0, 8'h20, 8'h00},
    '{8'hc1, 8'h04, 8'hf0, 8'hf0, 8'ha5}};

  always #12.5 clk = ~clk;

  e1_ovh_sel #(.FRAME_BITS(256), .BUF_DEPTH(2)) u_e1_ovh_sel (.clk_i(clk),
    .nrst_i(nrst), .reg_i(req), .rdata_o(rdata), .tx_serial_in_i(ser),
    .tx_serial_valid_i(s_valid), .tx_serial_ready_o(s_ready),
    .hdlc_bit_i(hbit), .tx_overhead_port_i(obit), .far_err_i(far_err),
    .hdlc_take_o(h_take), .ovh_take_o(o_take), .line_o(line),
    .line_valid_o(l_valid), .line_ready_i(l_ready));
  backplane_src u_backplane_src (.clk_i(clk), .nrst_i(nrst), .en_i(en),
    .ready_i(s_ready), .ser_o(ser), .valid_o(s_valid), .hdlc_o(hbit),
    .ovh_o(obit));

  // ****
  // shared tasks
  // ****
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(int i, logic [7:0] d);
    req <= '{addr: OFS[i], wdata: d, wr: 1'b1, rd: 1'b0};
    if (i < 5) shd[i] = d;
    @(posedge clk);
  endtask
  task automatic rd(int i);
    req <= '{addr: OFS[i], wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    rq.push_back(shd[i]);
    @(posedge clk);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // {hdlc used, overhead used, compared, value} for one accepted bit
  function automatic logic [3:0] expv(int f, int b, logic s, logic h, logic o);
    if (b >= 8 || (b == 3 && f % 2 == 1)) return {3'b001, s};
    if (f % 2 == 0 && b != 0) return {3'b001, act[0][0] ? s :
      e1_ovh_pkg::FAS_PAT[b]};
    if (b == 0) begin
      if (act[1][2] && f % 2 == 0) return {3'b001, act[0][1] ? s :
        ch[3 - (f % 8) / 2]};
      if (act[0][0]) return {3'b001, s};
      if (!act[1][2]) return 4'b0011;
      if (f == 13 || f == 15) return {3'b001, act[0][7:6] ==
        e1_ovh_pkg::EBIT_FAR ? far_err[f == 15] :
        act[0][7:6] != 2'h2};
      return {3'b001, e1_ovh_pkg::MF_PAT[f / 2]};
    end
    if (b == 1) return {3'b001, act[0][0] ? s : 1'b1};
    if (b == 2) return {3'b001, act[0][0] ? s : act[1][3]};
    if (act[3][b]) return {3'b001, act[4][b]};
    if (!act[2][b]) return 4'b0011;
    if (act[1][1:0] == e1_ovh_pkg::LINK_HDLC) return {3'b101, h};
    if (act[1][1:0] == e1_ovh_pkg::LINK_OVH) return {3'b011, o};
    return {3'b001, s};
  endfunction

  // ****
  // expectation side and watchers
  // ****
  always @(posedge clk) begin
    l_ready <= stall ? 1'b0 : 1'($random(seed));
    if (nrst) begin
      check("hdlc_take", {7'h0, ph}, {7'h0, h_take});
      check("ovh_take", {7'h0, po}, {7'h0, o_take});
      ph = 1'b0;
      po = 1'b0;
      if (s_valid && s_ready) begin
        e = expv(fr, bt, ser.data, hbit, obit);
        {ph, po} = e[3:2];
        eq.push_back(e[1:0]);
        // c positions of fas frames count as zero in the remainder
        cb = (bt == 0 && fr % 2 == 0) ? 1'b0 : e[0];
        cn = {cr[2], cr[1], cr[0] ^ cb ^ cr[3], cb ^ cr[3]};
        if (bt == 255 && fr % 8 == 7) begin
          ch = cn;
          cr = 4'h0;
        end else begin
          cr = cn;
        end
        nb++;
        bt = (bt + 1) % 256;
        // selections switch only between frames
        if (bt == 0) act = shd;
        if (bt == 0) fr = (fr + 1) % 16;
      end
    end
  end
  always @(posedge clk) begin
    if (rd_d) check("rdata", rq.pop_front(), rdata);
    rd_d <= nrst && req.rd;
    if (nrst && l_valid && l_ready) begin
      lq = eq.pop_front();
      if (lq[1]) check("line", {7'h0, lq[0]}, {7'h0, line.data});
    end
  end

  // ****
  // main sequence and watchdog
  // ****
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd(i);
    req <= '0;
    for (int p = 0; p < 6; p++) begin
      en <= 1'b0;
      do @(posedge clk); while (s_valid);
      for (int i = 0; i < 5; i++) wr(i, CFG[p][i]);
      wr(5, 8'h5a);
      for (int i = 0; i < 6; i++) rd(i);
      req <= '0;
      far_err <= 2'($random(seed));
      en <= 1'b1;
      stall <= (p == 0);
      repeat (12) @(posedge clk);
      #1 if (p == 0) check("ready", 8'h00, {7'h0, s_ready});
      stall <= 1'b0;
      tgt = nb + 16 * 256 + 37;
      while (nb < tgt) @(posedge clk);
    end
    en <= 1'b0;
    repeat (50) @(posedge clk);
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
